/* File: rtl/vocfg_top.v */
`timescale 1ns/1ps
`include "vocfg_regs.vh"

module vocfg_top (
  input wire clk_sys,
  input wire rstn,
  input wire [13:0] addr,
  input wire [7:0] wr_data,
  input wire wr_en,
  input wire rd_en,
  output wire [7:0] rd_data,
  input wire nv_prog_en,
  input wire [13:0] cpu_addr,
  input wire irq_pin_n,
  input wire [7:0] pb_pin,
  input wire [7:0] pb_is_input,
  input wire irq_ack,
  input wire [2:0] spi_oe_req,
  input wire [2:0] pd_ddr_spi,
  input wire spi_control_register_wired_or,
  input wire wdog_timeout,
  input wire clkmon_timeout,
  input wire rst_pin_i,
  output wire rst_pin_o,
  output wire rst_pin_oe,
  output wire ext_reset_req,
  output wire config_valid,
  output wire reduced_mode,
  output wire full_wdog_regs_en,
  output wire wdog_clear_pulse,
  output wire pd_ddr_en,
  output wire [2:0] spi_pin_oe,
  output wire pd_open_drain,
  output wire mem_disabled,
  output wire ram_win0_sel,
  output wire ram_win1_sel,
  output wire swopt_en,
  output wire [7:0] pb_pullup_en,
  output wire [7:0] pb_irq_en,
  output wire irq_edge_level,
  output wire irq_req,
  output wire reduced_wdog_en,
  output wire stop_clkmon_en
);

  // ----------------------------------------
  // Load sequencer states
  // ----------------------------------------
  // One store word per read, three edges in all
  localparam [1:0] ST_REQ_VOR = 2'b00;
  localparam [1:0] ST_REQ_PBO = 2'b01;
  localparam [1:0] ST_CAP_PBO = 2'b10;
  localparam [1:0] ST_RUN = 2'b11;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [7:0] vor_q;
  reg [7:0] pbo_q;
  reg reduced_q;
  reg [7:0] swopt_q;
  reg irq_wr_done_q;
  reg [7:0] rd_data_q;
  reg wclr_q;
  reg [2:0] spi_oe_q;
  reg pd_od_q;
  reg rst_oe_q;
  reg mem_dis_q;
  reg win0_q;
  reg win1_q;
  reg [7:0] pb_pu_q;
  reg [7:0] pb_ie_q;
  reg line_prev_q;
  reg irq_req_q;
  reg [7:0] vor_view;
  reg [7:0] rd_next;

  wire nv_we;
  wire nv_waddr;
  wire nv_raddr;
  wire [7:0] nv_rdata;
  wire [8:0] pins_s;
  wire irq_s_n;
  wire [7:0] pb_s;
  wire rst_pin_s;
  wire loaded;
  wire full;
  wire sw_wr;
  wire edge_level;
  wire line_low;
  wire irq_set;
  wire [7:0] pb_en_d;

  // ----------------------------------------
  // Nonvolatile option store
  // ----------------------------------------
  // Writable only in programming mode, which the programmer must finish first
  assign nv_we = wr_en & nv_prog_en & ((addr == `VOC_ADDR_VOR) | (addr == `VOC_ADDR_PBO));
  assign nv_waddr = (addr == `VOC_ADDR_PBO) ? `VOC_NV_IDX_PBO : `VOC_NV_IDX_VOR;
  // Read address follows the sequencer: VOR word in ST_REQ_VOR, PBO word in every later state
  assign nv_raddr = (state_q == ST_REQ_VOR) ? `VOC_NV_IDX_VOR : `VOC_NV_IDX_PBO;

  vocfg_nvstore #(
    .DW(8)
  ) u_nv (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .we(nv_we),
    .waddr(nv_waddr),
    .wdata(wr_data),
    .raddr(nv_raddr),
    .rdata(nv_rdata)
  );

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  vocfg_sync #(
    .W(9),
    .RST(9'h1FF)
  ) u_sync_pins (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .d({irq_pin_n, pb_pin}),
    .q(pins_s)
  );

  vocfg_sync #(
    .W(1),
    .RST(1'b1)
  ) u_sync_rst (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .d(rst_pin_i),
    .q(rst_pin_s)
  );

  assign irq_s_n = pins_s[8];
  assign pb_s = pins_s[7:0];
  // Our own drive of the pin also shows up here
  assign ext_reset_req = ~rst_pin_s;

  // ----------------------------------------
  // Load sequencer
  // ----------------------------------------
  always @* begin
    case (state_q)
      ST_REQ_VOR: state_d = ST_REQ_PBO;
      ST_REQ_PBO: state_d = ST_CAP_PBO;
      ST_CAP_PBO: state_d = ST_RUN;
      ST_RUN: state_d = ST_RUN;
      default: state_d = ST_REQ_VOR;
    endcase
  end

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_REQ_VOR;
      vor_q <= 8'h00;
      pbo_q <= 8'h00;
      reduced_q <= 1'b0;
    end else begin
      state_q <= state_d;
      // Captured once per reset, then never touched again
      if (state_q == ST_REQ_PBO) begin
        vor_q <= nv_rdata;
      end
      if (state_q == ST_CAP_PBO) begin
        pbo_q <= nv_rdata;
        reduced_q <= vor_q[`VOC_VOR_SEL];
      end
    end
  end

  assign loaded = (state_q == ST_RUN);
  assign full = ~reduced_q;

  // ----------------------------------------
  // Software option register
  // ----------------------------------------
  // Dead while reduced, so software cannot undo the fixed options
  assign sw_wr = wr_en & full & (addr == `VOC_ADDR_SWOPT);

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      swopt_q <= `VOC_SW_RST;
      irq_wr_done_q <= 1'b0;
    end else if (sw_wr) begin
      swopt_q[`VOC_SW_RAM0] <= wr_data[`VOC_SW_RAM0];
      swopt_q[`VOC_SW_RAM1] <= wr_data[`VOC_SW_RAM1];
      // Sensitivity may be changed only by the first write
      if (!irq_wr_done_q) begin
        swopt_q[`VOC_SW_IRQ] <= wr_data[`VOC_SW_IRQ];
      end
      irq_wr_done_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // Register read path
  // ----------------------------------------
  // Reads show the copy latched at reset, not the live store
  always @* begin
    vor_view = vor_q;
    if (full) begin
      vor_view = vor_q & ~`VOC_VOR_RMODE_MASK;
    end
    case (addr)
      `VOC_ADDR_VOR: rd_next = vor_view;
      `VOC_ADDR_PBO: rd_next = pbo_q;
      `VOC_ADDR_SWOPT: rd_next = full ? swopt_q : 8'h00;
      default: rd_next = 8'h00;
    endcase
  end

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rd_data_q <= 8'h00;
      wclr_q <= 1'b0;
    end else begin
      if (rd_en) begin
        rd_data_q <= rd_next;
      end
      // Write-only clear strobe for the reduced watchdog
      wclr_q <= wr_en & reduced_q & (addr == `VOC_ADDR_WCLR);
    end
  end

  assign rd_data = rd_data_q;
  assign wdog_clear_pulse = wclr_q;

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  // Full until the options are in, as power-on requires
  assign config_valid = loaded;
  assign reduced_mode = reduced_q;
  assign swopt_en = full;
  assign full_wdog_regs_en = full;
  assign pd_ddr_en = full;
  assign edge_level = full ? swopt_q[`VOC_SW_IRQ] : vor_q[`VOC_VOR_IRQ];
  assign irq_edge_level = edge_level;
  assign reduced_wdog_en = reduced_q & vor_q[`VOC_VOR_WDOG];
  assign stop_clkmon_en = reduced_q & vor_q[`VOC_VOR_STOP];

  // ----------------------------------------
  // Registered pin and map controls
  // ----------------------------------------
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      spi_oe_q <= 3'h0;
      pd_od_q <= 1'b0;
      rst_oe_q <= 1'b1;
      mem_dis_q <= 1'b0;
      win0_q <= 1'b0;
      win1_q <= 1'b0;
    end else begin
      // Reduced mode bypasses the direction bits
      spi_oe_q <= spi_oe_req & (pd_ddr_spi | {3{reduced_q}});
      pd_od_q <= full & spi_control_register_wired_or;
      // Held low until options are in, so the power-on pulse is seen
      rst_oe_q <= ~loaded | (full & (wdog_timeout | clkmon_timeout));
      // Map decode is registered, one cycle behind cpu_addr
      mem_dis_q <= reduced_q & (cpu_addr >= `VOC_GAP_LO) & (cpu_addr <= `VOC_GAP_HI);
      win0_q <= full & swopt_q[`VOC_SW_RAM0] & (cpu_addr >= `VOC_WIN0_LO) & (cpu_addr <= `VOC_WIN0_HI);
      win1_q <= full & swopt_q[`VOC_SW_RAM1] & (cpu_addr >= `VOC_WIN1_LO) & (cpu_addr <= `VOC_WIN1_HI);
    end
  end

  assign spi_pin_oe = spi_oe_q;
  assign pd_open_drain = pd_od_q;
  assign rst_pin_o = 1'b0;
  assign rst_pin_oe = rst_oe_q;
  assign mem_disabled = mem_dis_q;
  assign ram_win0_sel = win0_q;
  assign ram_win1_sel = win1_q;

  // ----------------------------------------
  // Port B pullup and interrupt enables
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pb
      // One option bit feeds both enables, input pins only
      assign pb_en_d[gi] = pbo_q[gi] & pb_is_input[gi];
    end
  endgenerate

  // One register pair keeps a single driver per vector
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pb_pu_q <= 8'h00;
      pb_ie_q <= 8'h00;
    end else begin
      pb_pu_q <= pb_en_d;
      pb_ie_q <= pb_en_d;
    end
  end

  assign pb_pullup_en = pb_pu_q;
  assign pb_irq_en = pb_ie_q;

  // ----------------------------------------
  // Shared external interrupt request
  // ----------------------------------------
  // IRQ pin and enabled port B pins are wire-ORed onto one line
  assign line_low = ~irq_s_n | (|(~pb_s & pb_ie_q));
  // Level mode re-arms every cycle the line stays low
  assign irq_set = loaded & line_low & (~line_prev_q | edge_level);

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      // Matches the idle line, so release makes no false edge
      line_prev_q <= 1'b0;
      irq_req_q <= 1'b0;
    end else begin
      line_prev_q <= line_low;
      // A new request in the acknowledge cycle is kept
      irq_req_q <= irq_set | (irq_req_q & ~irq_ack);
    end
  end

  assign irq_req = irq_req_q;

endmodule // vocfg_top

/* File: rtl/vocfg_regs.vh */
`ifndef VOCFG_REGS_VH
`define VOCFG_REGS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define VOC_ADDR_VOR 14'h3FF1
`define VOC_ADDR_PBO 14'h3FF2
`define VOC_ADDR_SWOPT 14'h3FDF
`define VOC_ADDR_WCLR 14'h3FF0

// ----------------------------------------
// Nonvolatile store entries
// ----------------------------------------
`define VOC_NV_IDX_VOR 1'h0
`define VOC_NV_IDX_PBO 1'h1

// ----------------------------------------
// Variant option register fields
// ----------------------------------------
`define VOC_VOR_SEL 0
`define VOC_VOR_IRQ 1
`define VOC_VOR_STOP 2
`define VOC_VOR_WDOG 3
`define VOC_VOR_RMODE_MASK 8'h0E

// ----------------------------------------
// Software option register fields
// ----------------------------------------
`define VOC_SW_RAM0 0
`define VOC_SW_RAM1 1
`define VOC_SW_IRQ 7
`define VOC_SW_RST 8'h80

// ----------------------------------------
// Memory map windows
// ----------------------------------------
`define VOC_WIN0_LO 14'h0020
`define VOC_WIN0_HI 14'h004F
`define VOC_WIN1_LO 14'h0100
`define VOC_WIN1_HI 14'h017F
`define VOC_GAP_LO 14'h0100
`define VOC_GAP_HI 14'h0FFF

`endif

/* File: rtl/vocfg_sync.v */
`timescale 1ns/1ps

// ----------------------------------------
// Two-stage level synchroniser
// ----------------------------------------
module vocfg_sync #(
  parameter W = 1,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  input wire clk_sys,
  input wire rstn,
  input wire [W-1:0] d,
  output wire [W-1:0] q
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      meta_q <= RST;
      sync_q <= RST;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;

endmodule // vocfg_sync

/* File: rtl/vocfg_nvstore.v */
`timescale 1ns/1ps

// ----------------------------------------
// Two-word nonvolatile option store
// ----------------------------------------
module vocfg_nvstore #(
  parameter DW = 8
) (
  input wire clk_sys,
  input wire rstn,
  input wire we,
  input wire waddr,
  input wire [DW-1:0] wdata,
  input wire raddr,
  output wire [DW-1:0] rdata
);

  reg [DW-1:0] mem_q [0:1];
  reg [DW-1:0] rdata_q;

  // Contents survive reset, like the cells they stand for
  always @(posedge clk_sys) begin
    if (we) begin
      mem_q[waddr] <= wdata;
    end
  end

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= {DW{1'b0}};
    end else begin
      rdata_q <= mem_q[raddr];
    end
  end

  assign rdata = rdata_q;

endmodule // vocfg_nvstore

/* File: tb/vocfg_chk.sv */
`timescale 1ns/1ps
`include "vocfg_regs.vh"
// ------
// Decode checker
// ------
module vocfg_chk (
  input wire clk_sys,
  input wire rstn,
  input wire wr_en,
  input wire nv_prog_en,
  input wire [2:0] spi_oe_req,
  input wire [2:0] pd_ddr_spi,
  input wire spi_control_register_wired_or,
  input wire rst_pin_oe,
  input wire config_valid,
  input wire reduced_mode,
  input wire swopt_en,
  input wire pd_ddr_en,
  input wire full_wdog_regs_en,
  input wire wdog_clear_pulse,
  input wire [2:0] spi_pin_oe,
  input wire pd_open_drain,
  input wire [7:0] pb_pullup_en,
  input wire [7:0] pb_irq_en,
  input wire [7:0] pb_is_input,
  input wire irq_req,
  input wire reduced_wdog_en,
  input wire stop_clkmon_en
);
  // Store reads unknown until programmed and reloaded by a reset
  reg prog_q = 1'b0;
  reg live_q = 1'b0;
  reg cv_q;
  always @(posedge clk_sys) if (wr_en && nv_prog_en) prog_q <= 1'b1;
  always @(negedge rstn) live_q <= prog_q;
  always @(posedge clk_sys or negedge rstn) if (!rstn) cv_q <= 1'b0; else cv_q <= config_valid;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn || !live_q);
  por_full_a:
    assert property (!config_valid |-> !reduced_mode) else $error("reduced before load");
  mode_gate_a:
    assert property (config_valid |-> swopt_en != reduced_mode && pd_ddr_en != reduced_mode
      && full_wdog_regs_en != reduced_mode) else $error("enables disagree with mode");
  spi_gate_a:
    assert property (cv_q |-> spi_pin_oe == (reduced_mode ? $past(spi_oe_req) : $past(spi_oe_req & pd_ddr_spi)))
      else $error("spi gating wrong");
  wired_or_a:
    assert property (cv_q |-> pd_open_drain == (!reduced_mode && $past(spi_control_register_wired_or))) else $error("wire-or wrong");
  opt_full_a:
    assert property (!reduced_mode |-> !reduced_wdog_en && !stop_clkmon_en) else $error("option leak in full");
  rst_in_a:
    assert property (cv_q && reduced_mode |-> !rst_pin_oe) else $error("reset pin driven in reduced");
  clr_mode_a:
    assert property (wdog_clear_pulse |-> reduced_mode) else $error("clear pulse in full");
  pb_pair_a:
    assert property (pb_pullup_en == pb_irq_en) else $error("pullup and irq enables differ");
  pb_input_a:
    assert property (cv_q |-> (pb_pullup_en & ~$past(pb_is_input)) == 8'h00) else $error("pullup on output pin");
  cover property (cv_q && reduced_mode && wdog_clear_pulse);
  cover property (cv_q && !reduced_mode && rst_pin_oe);
  cover property (cv_q && reduced_mode && irq_req);
endmodule // vocfg_chk

bind vocfg_top vocfg_chk u_chk (.clk_sys, .rstn, .wr_en, .nv_prog_en, .spi_oe_req, .pd_ddr_spi, .spi_control_register_wired_or,
  .rst_pin_oe, .config_valid, .reduced_mode, .swopt_en, .pd_ddr_en, .full_wdog_regs_en, .wdog_clear_pulse,
  .spi_pin_oe, .pd_open_drain, .pb_pullup_en, .pb_irq_en, .pb_is_input, .irq_req, .reduced_wdog_en,
  .stop_clkmon_en);

/* File: tb/vocfg_peer.sv */
`timescale 1ns/1ps
// ------
// Board side of reset and port B pins
// ------
module vocfg_peer (
  input wire rst_pin_o,
  input wire rst_pin_oe,
  input wire [7:0] pb_drv_low,
  output wire rst_pin_i,
  output wire [7:0] pb_pin
);
  // Board pull-ups hold released lines high
  assign rst_pin_i = rst_pin_oe ? rst_pin_o : 1'b1;
  assign pb_pin = ~pb_drv_low;
endmodule // vocfg_peer

/* File: tb/tb_vocfg_top.sv */
`timescale 1ns/1ps
`include "vocfg_regs.vh"
// ------
// Option decode bench
// ------
module tb_vocfg_top;
  reg clk_sys = 1'b0, rstn = 1'b0, wr_en = 1'b0, rd_en = 1'b0, nv_prog_en = 1'b0, irq_pin_n = 1'b1;
  reg irq_ack = 1'b0, spi_control_register_wired_or = 1'b1, wdog_timeout = 1'b0, clkmon_timeout = 1'b0;
  reg [13:0] addr = 14'h0000, cpu_addr = 14'h0000;
  reg [7:0] wr_data = 8'h00, pb_is_input = 8'hFF, pb_drv_low = 8'h00;
  reg [2:0] spi_oe_req = 3'h7, pd_ddr_spi = 3'h5;
  wire [7:0] rd_data, pb_pin, pb_pullup_en, pb_irq_en;
  wire [2:0] spi_pin_oe;
  wire rst_pin_i, rst_pin_o, rst_pin_oe, ext_reset_req, config_valid, reduced_mode, full_wdog_regs_en;
  wire wdog_clear_pulse, pd_ddr_en, pd_open_drain, mem_disabled, ram_win0_sel, ram_win1_sel, swopt_en;
  wire irq_edge_level, irq_req, reduced_wdog_en, stop_clkmon_en;
  integer n_fail = 0, n_tests = 0, cyc = 0;
  vocfg_top dut (.clk_sys, .rstn, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .nv_prog_en, .cpu_addr, .irq_pin_n,
    .pb_pin, .pb_is_input, .irq_ack, .spi_oe_req, .pd_ddr_spi, .spi_control_register_wired_or, .wdog_timeout, .clkmon_timeout,
    .rst_pin_i, .rst_pin_o, .rst_pin_oe, .ext_reset_req, .config_valid, .reduced_mode, .full_wdog_regs_en,
    .wdog_clear_pulse, .pd_ddr_en, .spi_pin_oe, .pd_open_drain, .mem_disabled, .ram_win0_sel, .ram_win1_sel,
    .swopt_en, .pb_pullup_en, .pb_irq_en, .irq_edge_level, .irq_req, .reduced_wdog_en, .stop_clkmon_en);
  vocfg_peer u_peer (.rst_pin_o, .rst_pin_oe, .pb_drv_low, .rst_pin_i, .pb_pin);
  initial forever #2 clk_sys = ~clk_sys;
  task wrap_up;
    begin
      $display("tests %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      n_fail = n_fail + 1;
      wrap_up;
    end
  end
  task chk(input [7:0] s, input [7:0] e);
    begin
      n_tests = n_tests + 1;
      if (s !== e) begin
        n_fail = n_fail + 1;
        $display("[ERR] %0t got %h want %h", $time, s, e);
      end
    end
  endtask
  task tk(input integer n);
    repeat (n) @(posedge clk_sys);
  endtask
  task wr(input [13:0] a, input [7:0] d);
    begin
      @(posedge clk_sys);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clk_sys);
      wr_en <= 1'b0;
    end
  endtask
  task rd(input [13:0] a, input [7:0] e);
    begin
      @(posedge clk_sys);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk_sys);
      rd_en <= 1'b0;
      #1;
      chk(rd_data, e);
    end
  endtask
  task mp(input [13:0] a, input [2:0] e);
    begin
      @(posedge clk_sys);
      cpu_addr <= a;
      tk(2);
      #1;
      chk({ram_win0_sel, ram_win1_sel, mem_disabled}, e);
    end
  endtask
  task ak(input e);
    begin
      @(posedge clk_sys);
      irq_ack <= 1'b1;
      @(posedge clk_sys);
      irq_ack <= 1'b0;
      tk(3);
      #1;
      chk(irq_req, e);
    end
  endtask
  task load(input [7:0] v);
    begin
      @(posedge clk_sys);
      nv_prog_en <= 1'b1;
      wr(`VOC_ADDR_VOR, v);
      wr(`VOC_ADDR_PBO, 8'h0F);
      nv_prog_en <= 1'b0;
      rstn <= 1'b0;
      tk(3);
      rstn <= 1'b1;
      tk(6);
      #1;
    end
  endtask
  initial begin
    tk(2);
    #1;
    chk({rst_pin_oe, reduced_mode}, 2'h2);
    tk(18);
    rstn <= 1'b1;
    tk(3);
    load(8'h0E);
    chk({config_valid, swopt_en, pd_ddr_en, full_wdog_regs_en}, 4'hF);
    chk({reduced_wdog_en, stop_clkmon_en, spi_pin_oe, pd_open_drain}, 6'h0B);
    chk(pb_pullup_en, 8'h0F);
    chk(pb_irq_en, 8'h0F);
    @(posedge clk_sys);
    pb_is_input <= 8'hFE;
    tk(2);
    #1;
    chk(pb_pullup_en | pb_irq_en, 8'h0E);
    @(posedge clk_sys);
    pb_is_input <= 8'hFF;
    rd(`VOC_ADDR_VOR, 8'h00);
    rd(`VOC_ADDR_WCLR, 8'h00);
    rd(`VOC_ADDR_PBO, 8'h0F);
    wr(`VOC_ADDR_WCLR, 8'h55);
    #1;
    chk(wdog_clear_pulse, 1'b0);
    rd(`VOC_ADDR_SWOPT, `VOC_SW_RST);
    wr(`VOC_ADDR_SWOPT, 8'h03);
    wr(`VOC_ADDR_SWOPT, 8'h83);
    rd(`VOC_ADDR_SWOPT, 8'h03);
    chk(irq_edge_level, 1'b0);
    mp(`VOC_WIN0_HI, 3'h4);
    mp(`VOC_WIN1_LO, 3'h2);
    mp(`VOC_GAP_HI, 3'h0);
    @(posedge clk_sys);
    pb_drv_low <= 8'h20;
    tk(6);
    #1;
    chk(irq_req, 1'b0);
    @(posedge clk_sys);
    pb_drv_low <= 8'h21;
    tk(6);
    #1;
    chk(irq_req, 1'b1);
    ak(1'b0);
    @(posedge clk_sys);
    pb_drv_low <= 8'h00;
    wdog_timeout <= 1'b1;
    tk(1);
    #1;
    chk({rst_pin_oe, rst_pin_o}, 2'h2);
    // Hold long enough to cross the pin synchroniser
    tk(4);
    #1;
    chk(ext_reset_req, 1'b1);
    @(posedge clk_sys);
    wdog_timeout <= 1'b0;
    clkmon_timeout <= 1'b1;
    tk(2);
    #1;
    chk(rst_pin_oe, 1'b1);
    @(posedge clk_sys);
    clkmon_timeout <= 1'b0;
    load(8'h0F);
    chk({config_valid, swopt_en, pd_ddr_en, full_wdog_regs_en}, 4'h8);
    chk({reduced_wdog_en, stop_clkmon_en, irq_edge_level}, 3'h7);
    chk({spi_pin_oe, pd_open_drain, rst_pin_oe}, 5'h1C);
    rd(`VOC_ADDR_VOR, 8'h0F);
    wr(`VOC_ADDR_WCLR, 8'h55);
    #1;
    chk(wdog_clear_pulse, 1'b1);
    @(posedge clk_sys);
    #1;
    chk(wdog_clear_pulse, 1'b0);
    wr(`VOC_ADDR_SWOPT, 8'h03);
    rd(`VOC_ADDR_SWOPT, 8'h00);
    mp(`VOC_WIN0_HI, 3'h0);
    mp(`VOC_GAP_LO, 3'h1);
    mp(`VOC_GAP_HI, 3'h1);
    mp(14'h1000, 3'h0);
    @(posedge clk_sys);
    clkmon_timeout <= 1'b1;
    tk(4);
    #1;
    chk({rst_pin_oe, ext_reset_req}, 2'h0);
    @(posedge clk_sys);
    clkmon_timeout <= 1'b0;
    irq_pin_n <= 1'b0;
    tk(5);
    #1;
    chk(irq_req, 1'b1);
    ak(1'b1);
    @(posedge clk_sys);
    irq_pin_n <= 1'b1;
    tk(4);
    ak(1'b0);
    wrap_up;
  end
endmodule // tb_vocfg_top
